// ---- logic/dsc_pkg.sv ----
// Shared constants, field layout and types of the serial setup port
package dsc_pkg;

  // Core clock rate
  localparam int CLK_MHZ  = 100;
  localparam int NS_PER_US = 1000;

  // Converter geometry
  localparam int CHANNELS     = 8;
  localparam int WORD_W       = 16;
  localparam int SECOND_WORDS = 4;
  localparam int FCNT_W       = 8;
  localparam int RCNT_W       = 5;
  localparam int CYC_W        = 12;

  // Setup word layout
  localparam logic [15:0] SETUP_DEFAULT = 16'hFFFF;
  localparam int UPDATE_BIT   = 15;
  localparam int CHSEL_HI     = 14;
  localparam int CHSEL_LO     = 13;
  localparam int GAIN_HI      = 11;
  localparam int GAIN_LO      = 4;
  localparam int REFON_BIT    = 2;
  localparam int CMS_BIT      = 1;
  localparam int SDO2_OFF_BIT = 0;

  // Conversion phase length per channel, arbitrary plain defaults
  localparam int NORMAL_CH_NS = 1000;
  localparam int WARP_CH_NS   = 800;

  // Conversions treated as undefined after leaving power-down
  localparam logic [1:0] WARMUP_CONV = 2'h2;

  typedef logic [WORD_W-1:0] dsc_word_t;
  typedef logic [CHANNELS-1:0][WORD_W-1:0] dsc_results_t;

  typedef struct packed {
    logic [3:0] chan_count;
    logic [7:0] gain_select;
    logic       internal_reference_on;
    logic       conversion_mode_select;
  } dsc_cfg_t;

  // Least time rounds up, never below one cycle
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    return (c < 1) ? 1 : c;
  endfunction

  // 00/01/10/11 select 2/4/6/8 channels
  function automatic logic [3:0] chan_count(input logic [1:0] sel);
    return {1'b0, sel, 1'b0} + 4'h2;
  endfunction

endpackage

// ---- logic/dsc_serial_config_port.sv ----
// Conversion sequencer, setup word pipeline and 4-wire readout port
//
// Operation
// [RULE_01] Reset or power-down aborts conversion and floats serial out.
// [RULE_02] Host holds reset high for its minimum pulse width.
// [RULE_03] With default setup, host waits acquisition time before start.
// [RULE_04] Reset clears stored results; early reads return invalid data.
// [RULE_05] First two conversions after power-down are undefined.
// [RULE_06] Serial out driver enabled only while chip select is low.
// [RULE_07] Result bits change on falling shift edges; host sends setup.
// [RULE_08] Shift clock may idle high or low between transfers.
// [RULE_09] Split off: channels 0 to 7 shift out MSB first in order.
// [RULE_10] Chip select high: combined pin shows busy.
// [RULE_11] Setup bit 0 selects second data output after conversion.
// [RULE_12] Split on: serial out carries 0-3, second pin carries 4-7.
// [RULE_13] Results are presented in two's complement coding.
// [RULE_14] Host avoids port traffic during the quiet conversion phase.
// [RULE_15] Results and active setup update at end of conversion.
// [RULE_16] Sixteen edges per result, then sixteen for the setup word.
// [RULE_17] Host waits aperture delay after sampling before access.
// [RULE_18] Setup captured on first 16 rising edges, applied next end.
// [RULE_19] Readback returns setup of the current conversion.
// [RULE_20] Leaving reset loads the all-ones default setup word.
// [RULE_21] Power-down exit keeps setup; dummy conversion needed.
// [RULE_22] Default selects update, 8 channels, widest gain, normal mode.
// [RULE_23] Bit 15 set overwrites setup; clear keeps current setup.
// [RULE_24] Bits 14:13 choose 2, 4, 6 or 8 channels.
// [RULE_25] Gain fields in bits 11:4 encode four input ranges.
// [RULE_26] Bit 1 selects warp mode or normal mode.
// [RULE_27] Edge counting restarts with every chip-select-low transfer.
`timescale 1ns/1ps

module dsc_serial_config_port #(
  parameter int NORMAL_NS = dsc_pkg::NORMAL_CH_NS, // Normal phase per channel
  parameter int WARP_NS   = dsc_pkg::WARP_CH_NS    // Warp phase per channel
) (
  input  wire logic                 clk,                // Core clock
  input  wire logic                 resetn,             // Sync reset, low
  input  wire logic                 sck,                // Host shift clock
  input  wire logic                 cs_n,               // Chip select, low
  input  wire logic                 din,                // Setup word in
  input  wire logic                 convert_start,      // Start pin
  input  wire logic                 reset_in,           // Reset pin, high
  input  wire logic                 power_down_in,      // Power-down pin
  input  wire dsc_pkg::dsc_results_t sample_codes,      // Front-end codes
  output logic                      serial_out,         // Serial data out
  output logic                      serial_out_oe,      // Driver enable
  output logic                      busy_or_second_out, // Busy or data 2
  output dsc_pkg::dsc_cfg_t         active_cfg          // Applied setup
);
  import dsc_pkg::*;

  typedef enum logic {ST_IDLE, ST_CONV} dsc_state_t;

  localparam logic [CYC_W-1:0] NORMAL_CYC = CYC_W'(ns_to_cycles(NORMAL_NS));
  localparam logic [CYC_W-1:0] WARP_CYC   = CYC_W'(ns_to_cycles(WARP_NS));
  localparam logic [FCNT_W-1:0] FCNT_MAX  = {FCNT_W{1'b1}};
  localparam logic [RCNT_W-1:0] RCNT_LAST = RCNT_W'(WORD_W - 1);

  // Clock-domain crossings into clk
  logic [1:0] cnv_sync_r;
  logic [1:0] rst_sync_r;
  logic [1:0] pd_sync_r;
  logic [1:0] done_sync_r;
  logic       cnv_prev_r;
  logic       pd_prev_r;
  logic       done_prev_r;

  // Core state
  dsc_state_t       state_r;
  logic             busy_r;
  logic [CYC_W-1:0] cyc_r;
  logic [2:0]       ch_r;
  dsc_word_t        active_r;
  dsc_word_t        rd_word_r;
  dsc_word_t        pend_r;
  logic             pend_vld_r;
  dsc_results_t     results_r;
  logic             data_vld_r;
  logic [1:0]       warm_r;
  logic             oe_allow_r;
  logic             second_en_r;

  // Link-side state
  logic [RCNT_W-1:0] rcnt_r;
  logic              cap_done_r;
  dsc_word_t         shift_r;
  logic [FCNT_W-1:0] fcnt_r;
  logic              so_r;
  logic              so2_r;

  logic             rst_hold;
  logic             pd_hold;
  logic             cnv_rise;
  logic             pd_fall;
  logic             take_word;
  logic [3:0]       nch;
  logic [CYC_W-1:0] ch_cycles;
  logic             eoc;

  // Picks the bit a falling edge presents on either data pin
  function automatic logic pick_bit(input dsc_results_t res,
                                    input dsc_word_t    rdw,
                                    input logic [FCNT_W-1:0] k,
                                    input logic         second);
    logic [3:0] w;
    logic [3:0] b;
    logic [3:0] last;
    logic       split;
    w     = k[FCNT_W-1:4];
    b     = ~k[3:0];                               // MSB first [RULE_09]
    split = ~rdw[SDO2_OFF_BIT];
    last  = split ? 4'(SECOND_WORDS)
                  : chan_count(rdw[CHSEL_HI:CHSEL_LO]);
    pick_bit = 1'b0;
    if (second) begin
      if (w < 4'(SECOND_WORDS)) begin
        pick_bit = res[w[2:0] + 3'(SECOND_WORDS)][b]; // [RULE_12]
      end
    end else if (w < last) begin
      pick_bit = res[w[2:0]][b];                   // [RULE_09] [RULE_16]
    end else if (w == last) begin
      pick_bit = rdw[b];                           // [RULE_16] [RULE_19]
    end
  endfunction

  // Two flip-flops on the start, reset and power-down pins and the capture flag, then a third stage for edges
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnv_sync_r  <= 2'h0;
      rst_sync_r  <= 2'h0;
      pd_sync_r   <= 2'h0;
      done_sync_r <= 2'h0;
      cnv_prev_r  <= 1'b0;
      pd_prev_r   <= 1'b0;
      done_prev_r <= 1'b0;
    end else begin
      cnv_sync_r  <= {cnv_sync_r[0], convert_start};
      rst_sync_r  <= {rst_sync_r[0], reset_in};
      pd_sync_r   <= {pd_sync_r[0], power_down_in};
      done_sync_r <= {done_sync_r[0], cap_done_r};
      cnv_prev_r  <= cnv_sync_r[1];
      pd_prev_r   <= pd_sync_r[1];
      done_prev_r <= done_sync_r[1];
    end
  end

  assign rst_hold  = rst_sync_r[1];
  assign pd_hold   = pd_sync_r[1];
  assign cnv_rise  = cnv_sync_r[1] & ~cnv_prev_r;
  assign pd_fall   = pd_prev_r & ~pd_sync_r[1];
  assign take_word = done_sync_r[1] & ~done_prev_r;

  // Channel count and phase length follow the applied setup
  assign nch       = chan_count(active_r[CHSEL_HI:CHSEL_LO]);   // [RULE_24]
  assign ch_cycles = active_r[CMS_BIT] ? NORMAL_CYC : WARP_CYC; // [RULE_26]
  assign eoc = (state_r == ST_CONV) && (cyc_r == ch_cycles - 1'b1)
               && ({1'b0, ch_r} == nch - 1'b1);

  // Conversion sequencer; starts during a conversion are ignored
  always_ff @(posedge clk) begin
    if (!resetn || rst_hold || pd_hold) begin
      state_r <= ST_IDLE;                          // [RULE_01]
      busy_r  <= 1'b0;
      cyc_r   <= '0;
      ch_r    <= 3'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cnv_rise) begin
            state_r <= ST_CONV;
            busy_r  <= 1'b1;
            cyc_r   <= '0;
            ch_r    <= 3'h0;
          end
        end
        ST_CONV: begin
          if (cyc_r == ch_cycles - 1'b1) begin
            cyc_r <= '0;
            if (eoc) begin
              state_r <= ST_IDLE;
              busy_r  <= 1'b0;
            end else begin
              ch_r <= ch_r + 3'h1;
            end
          end else begin
            cyc_r <= cyc_r + 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // Setup pipeline: captured word waits for the next end of conversion
  always_ff @(posedge clk) begin
    if (!resetn || rst_hold) begin
      active_r   <= SETUP_DEFAULT;                 // [RULE_20] [RULE_22]
      rd_word_r  <= SETUP_DEFAULT;
      pend_r     <= SETUP_DEFAULT;
      pend_vld_r <= 1'b0;
    end else begin
      if (eoc) begin
        rd_word_r <= active_r;                     // [RULE_19]
        if (pend_vld_r) begin
          active_r <= pend_r;                      // [RULE_15] [RULE_18]
        end
        pend_vld_r <= 1'b0;
      end
      // Power-down leaves setup untouched but ignores the port
      if (take_word && !pd_hold && shift_r[UPDATE_BIT]) begin
        pend_r     <= shift_r;                     // [RULE_23] [RULE_21]
        pend_vld_r <= 1'b1;                        // Set wins over clear
      end
    end
  end

  // Result store, loaded only at the end of a conversion
  always_ff @(posedge clk) begin
    if (!resetn || rst_hold) begin
      results_r  <= '0;                            // [RULE_04]
      data_vld_r <= 1'b0;
      warm_r     <= 2'h0;
    end else begin
      if (cnv_rise && state_r == ST_IDLE && !pd_hold) begin
        data_vld_r <= 1'b0;                        // [RULE_15]
      end
      if (pd_fall) begin
        warm_r <= WARMUP_CONV;                     // [RULE_05]
      end
      if (eoc) begin
        data_vld_r <= 1'b1;                        // [RULE_15]
        for (int i = 0; i < CHANNELS; i++) begin
          // Codes pass through unchanged as two's complement
          results_r[i] <= (4'(i) < nch && warm_r == 2'h0)
                          ? sample_codes[i] : '0;  // [RULE_13] [RULE_05]
        end
        if (warm_r != 2'h0) begin
          warm_r <= warm_r - 2'h1;                 // [RULE_05]
        end
      end
    end
  end

  // Pin driver controls; power-down floats serial out, but the second data pin is not gated by it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      oe_allow_r  <= 1'b0;
      second_en_r <= 1'b0;
    end else begin
      oe_allow_r  <= ~rst_hold & ~pd_hold;         // [RULE_01]
      second_en_r <= data_vld_r & ~rd_word_r[SDO2_OFF_BIT]; // [RULE_11]
    end
  end

  // Rising edges capture the setup word; counters restart per frame.
  // Only the first sixteen edges shift, so the word stays put for clk.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rcnt_r     <= '0;                            // [RULE_27]
      cap_done_r <= 1'b0;
    end else if (!rcnt_r[RCNT_W-1]) begin
      rcnt_r <= rcnt_r + 1'b1;
      if (rcnt_r == RCNT_LAST) begin
        cap_done_r <= 1'b1;                        // [RULE_18]
      end
    end
  end

  // Setup shift register, held once sixteen bits are in
  always_ff @(posedge sck) begin
    if (!cs_n && !rcnt_r[RCNT_W-1]) begin
      shift_r <= {shift_r[WORD_W-2:0], din};       // [RULE_07] [RULE_18]
    end
  end

  // Falling edge counter, restarted by every frame
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      fcnt_r <= '0;                                // [RULE_27] [RULE_08]
    end else if (fcnt_r != FCNT_MAX) begin
      fcnt_r <= fcnt_r + 1'b1;
    end
  end

  // Results and setup are quasi-static: they move only at end of
  // conversion, and the host keeps the port quiet while converting.
  always_ff @(negedge sck) begin
    so_r  <= pick_bit(results_r, rd_word_r, fcnt_r, 1'b0); // [RULE_07] [RULE_14]
    so2_r <= pick_bit(results_r, rd_word_r, fcnt_r, 1'b1); // [RULE_12]
  end

  // Raw chip select gates the drivers so none lingers after a frame
  assign serial_out    = so_r;
  assign serial_out_oe = oe_allow_r & ~cs_n;       // [RULE_06] [RULE_01]
  assign busy_or_second_out = (cs_n | ~second_en_r)
                              ? busy_r : so2_r;    // [RULE_10] [RULE_11]

  // Applied setup fields for the analog front end
  assign active_cfg.chan_count             = nch;  // [RULE_24]
  assign active_cfg.gain_select            = active_r[GAIN_HI:GAIN_LO]; // [RULE_25]
  assign active_cfg.internal_reference_on  = active_r[REFON_BIT];
  assign active_cfg.conversion_mode_select = active_r[CMS_BIT]; // [RULE_26]

endmodule

// ---- tb/dsc_host_model.sv ----
// Host serial master model: frames, shift clock and setup word
`timescale 1ns/1ps
module dsc_host_model (
  output logic      sck,  // Shift clock, still outside frames
  output logic      cs_n, // Chip select, low
  output logic      din,  // Setup word out
  input  wire logic so,   // Serial data seen
  input  wire logic so2   // Second data pin seen
);
  initial begin
    sck = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // One frame of n bits at 48 ns; data sampled on each rise
  task automatic frame(input int n, input logic [15:0] w, input logic hi,
                       output logic [143:0] a, output logic [143:0] b);
    int idx;
    a = '0;
    b = '0;
    #0.3; // Keeps shift edges off the core clock grid
    sck = hi;
    din = w[15];
    #10 cs_n = 1'b0;
    #24;
    if (!hi) begin
      sck = 1'b1; // Idle low: this first rise takes the MSB
      #24;
    end
    for (int j = 0; j < n; j++) begin
      idx = hi ? 15 - j : 14 - j;
      sck = 1'b0;
      din = (idx >= 0) ? w[idx] : ~din;
      #24;
      sck = 1'b1;
      a = {a[142:0], so};
      b = {b[142:0], so2};
      #24;
    end
    #10 cs_n = 1'b1; // Hold past the last rise
    din = ~din;
    #10 sck = hi;
  endtask
endmodule

// ---- tb/dsc_port_monitor.sv ----
// Pin-level checker of the serial setup port, bound to the port module
`timescale 1ns/1ps
module dsc_port_monitor #(
  parameter int NORMAL_NS = 1000, // Normal phase per channel
  parameter int WARP_NS   = 800   // Warp phase per channel
) (
  input wire logic                  clk,                // Core clock
  input wire logic                  resetn,             // Sync reset, low
  input wire logic                  sck,                // Shift clock
  input wire logic                  cs_n,               // Chip select
  input wire logic                  din,                // Setup word in
  input wire logic                  convert_start,      // Start pin
  input wire logic                  reset_in,           // Reset pin
  input wire logic                  power_down_in,      // Power-down pin
  input wire dsc_pkg::dsc_results_t sample_codes,       // Front-end codes
  input wire logic                  serial_out,         // Serial data
  input wire logic                  serial_out_oe,      // Driver enable
  input wire logic                  busy_or_second_out, // Busy or data 2
  input wire dsc_pkg::dsc_cfg_t     active_cfg          // Applied setup
);
  // Phase lengths round up to whole core cycles
  localparam int NCYC = (NORMAL_NS * dsc_pkg::CLK_MHZ + 999) / 1000;
  localparam int WCYC = (WARP_NS * dsc_pkg::CLK_MHZ + 999) / 1000;
  logic [11:0] cnt_r;
  logic [11:0] exp_r;
  wire         busy = cs_n & busy_or_second_out;

  // Busy length counter; expectation frozen while busy, as cfg moves at EOC
  always_ff @(posedge clk) begin
    cnt_r <= (!resetn || !busy) ? 12'h000 : cnt_r + 12'h001;
  end
  always_ff @(posedge clk) begin
    if (!busy)
      exp_r <= 12'(active_cfg.chan_count) *
               12'(active_cfg.conversion_mode_select ? NCYC : WCYC);
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_oe_gate: assert property (serial_out_oe |-> !cs_n)
    else $error("serial out driven with chip select high");
  chk_reset_float: assert property (
    reset_in [*6] |-> !serial_out_oe && !busy)
    else $error("reset pin did not abort or float");
  chk_pd_float: assert property (
    power_down_in [*6] |-> !serial_out_oe && !busy)
    else $error("power-down did not abort or float");
  chk_default_cfg: assert property (
    $rose(resetn) |-> active_cfg == {4'h8, 8'hFF, 2'h3})
    else $error("setup not default after reset");
  chk_cfg_at_eoc: assert property (
    $changed(active_cfg) && !reset_in |-> cs_n && $fell(busy_or_second_out))
    else $error("setup changed away from end of conversion");
  chk_busy_start: assert property (
    $rose(convert_start) && !busy && cs_n && !reset_in && !power_down_in
    |-> ##[2:5] (busy || !cs_n))
    else $error("start did not raise busy");
  chk_busy_len: assert property (
    $fell(busy) && cs_n && !reset_in && !power_down_in |-> cnt_r == exp_r)
    else $error("conversion length wrong");
  chk_shift_edge: assert property (
    $changed(serial_out) && !cs_n && !$past(cs_n) |-> $fell(sck))
    else $error("serial out moved off a falling edge");
endmodule

bind dsc_serial_config_port dsc_port_monitor #(
  .NORMAL_NS(NORMAL_NS), .WARP_NS(WARP_NS)) u_mon (
  .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .din(din),
  .convert_start(convert_start), .reset_in(reset_in),
  .power_down_in(power_down_in), .sample_codes(sample_codes),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .busy_or_second_out(busy_or_second_out), .active_cfg(active_cfg));

// ---- tb/dsc_serial_config_port_tb.sv ----
// Self-checking bench of the serial setup port with a host model
`timescale 1ns/1ps
module dsc_serial_config_port_tb;
  import dsc_pkg::*;
  localparam logic [15:0] W1 = 16'hE5A4; // 8 ch, warp, split on
  logic         clk, resetn, convert_start, reset_in, power_down_in;
  logic         serial_out, serial_out_oe, busy_or_second_out;
  wire          sck, cs_n, din;
  dsc_cfg_t     active_cfg;
  dsc_results_t sample_codes;
  int           failures, n_tests;
  logic [143:0] ra, rb;
  // Released line shows the inverse, never a stale value
  wire          so_w = serial_out_oe ? serial_out : ~serial_out;

  dsc_serial_config_port #(.NORMAL_NS(50), .WARP_NS(40)) dut (
    .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .din(din),
    .convert_start(convert_start), .reset_in(reset_in),
    .power_down_in(power_down_in), .sample_codes(sample_codes),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .busy_or_second_out(busy_or_second_out), .active_cfg(active_cfg));
  dsc_host_model host (.sck(sck), .cs_n(cs_n), .din(din), .so(so_w),
    .so2(busy_or_second_out));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] code(input int i);
    return 16'h8000 | 16'(i * 16'h0911);
  endfunction
  function automatic logic [15:0] ecfg(input logic [15:0] w);
    return {2'h0, 4'(2 + 2 * w[14:13]), w[11:4], w[2], w[1]};
  endfunction
  function automatic logic [15:0] wd(input logic [143:0] a, int n, int k);
    return a[n - 1 - 16 * k -: 16];
  endfunction

  task automatic chk(input string what, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h got %h", what, e, g);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One conversion; the port stays idle until busy has fallen
  task automatic conv;
    int i;
    @(posedge clk) convert_start <= 1'b1;
    // Busy is looked at on falling clock edges, where it has settled
    for (i = 0; i < 20 && busy_or_second_out !== 1'b1; i++) @(negedge clk);
    chk("busy start", 16'h1, {15'h0, busy_or_second_out});
    for (i = 0; i < 200 && busy_or_second_out !== 1'b0; i++) @(negedge clk);
    @(posedge clk) convert_start <= 1'b0;
    chk("busy end", 16'h0, {15'h0, busy_or_second_out});
    repeat (3) @(posedge clk);
  endtask

  task automatic t_early;
    chk("reset cfg", ecfg(16'hFFFF), {2'h0, active_cfg});
    host.frame(16, 16'h7FFF, 1'b1, ra, rb);
    chk("early read", 16'h0, ra[15:0]);
    repeat (10) @(posedge clk);
    $display("test early done");
  endtask
  task automatic t_readout;
    conv();
    host.frame(144, W1, 1'b0, ra, rb);
    for (int k = 0; k < 8; k++) chk("ch", code(k), wd(ra, 144, k));
    chk("setup rd", 16'hFFFF, wd(ra, 144, 8));
    chk("cfg held", ecfg(16'hFFFF), {2'h0, active_cfg});
    $display("test readout done");
  endtask
  task automatic t_pipeline;
    conv();
    chk("cfg new", ecfg(W1), {2'h0, active_cfg});
    host.frame(144, 16'h0123, 1'b1, ra, rb);
    chk("ch7", code(7), wd(ra, 144, 7));
    chk("setup cur", 16'hFFFF, wd(ra, 144, 8));
    $display("test pipeline done");
  endtask
  task automatic t_split;
    conv();
    chk("cfg kept", ecfg(W1), {2'h0, active_cfg});
    host.frame(80, 16'h0000, 1'b1, ra, rb);
    for (int k = 0; k < 4; k++) begin
      chk("ch lo", code(k), wd(ra, 80, k));
      chk("ch hi", code(k + 4), wd(rb, 80, k));
    end
    chk("setup split", W1, wd(ra, 80, 4));
    $display("test split done");
  endtask
  task automatic t_pd;
    @(posedge clk) power_down_in <= 1'b1;
    repeat (8) @(posedge clk);
    convert_start <= 1'b1;
    repeat (8) @(posedge clk);
    convert_start <= 1'b0;
    chk("pd busy", 16'h0, {15'h0, busy_or_second_out});
    host.frame(16, 16'hA000, 1'b1, ra, rb);
    @(posedge clk) power_down_in <= 1'b0;
    repeat (5) @(posedge clk);
    conv();
    host.frame(16, 16'h0000, 1'b0, ra, rb);
    chk("warm read", 16'h0, ra[15:0]);
    conv();
    chk("pd cfg", ecfg(W1), {2'h0, active_cfg});
    $display("test power_down done");
  endtask
  task automatic t_abort;
    @(posedge clk) convert_start <= 1'b1;
    repeat (6) @(posedge clk);
    reset_in <= 1'b1;
    convert_start <= 1'b0;
    repeat (6) @(posedge clk);
    chk("abort busy", 16'h0, {15'h0, busy_or_second_out});
    reset_in <= 1'b0;
    repeat (6) @(posedge clk);
    t_early();
    $display("test abort done");
  endtask
  task automatic t_chsel;
    logic [15:0] w;
    for (int s = 0; s < 4; s++) begin
      // Reference enable toggles too, so a stuck field shows up
      w = {1'b1, 2'(s), 10'h3FF, s[1], 2'h3};
      host.frame(16, w, s[0], ra, rb);
      conv();
      chk("chan sel", ecfg(w), {2'h0, active_cfg});
    end
    conv();
    $display("test chsel done");
  endtask

  initial begin
    resetn = 1'b0;
    convert_start = 1'b0;
    reset_in = 1'b0;
    power_down_in = 1'b0;
    failures = 0;
    n_tests = 0;
    for (int i = 0; i < 8; i++) sample_codes[i] = code(i);
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    t_early();
    t_readout();
    t_pipeline();
    t_split();
    t_pd();
    t_abort();
    t_chsel();
    conclude();
  end

  // Whole run is near 30 us; this cuts a hang short
  initial begin
    #200000;
    failures++;
    $display("Error watchdog expected done got timeout");
    conclude();
  end
endmodule
